/* hw/cct_pkg.sv */
/*
 * Package for the processor clock throttle control block: register offsets,
 * field positions, reset values, timing counts and shared types.
 * Assumes a single 200 MHz clock and a synchronous 32 kHz time base input.
 */
package cct_pkg;
    localparam logic [7:0]  OFS_ROUTE   = 8'h04;
    localparam logic [7:0]  OFS_GENERAL_PURPOSE_EVENT_ENABLE    = 8'h0E;
    localparam logic [7:0]  OFS_PCTL    = 8'h10;
    localparam logic [7:0]  OFS_LEVEL2_ENTRY_REG    = 8'h14;
    localparam logic [7:0]  OFS_LEVEL3_ENTRY_REG    = 8'h15;
    localparam logic [7:0]  OFS_GLOBAL_EVENT_ENABLE   = 8'h20;
    localparam logic [7:0]  OFS_INTPIN  = 8'h3D;
    localparam logic [7:0]  OFS_FBCNT   = 8'h48;
    localparam logic [7:0]  OFS_STATE   = 8'h50;
    localparam logic [15:0] RST16       = 16'h0000;
    localparam logic [7:0]  RST8        = 8'h00;
    localparam int          B_SCI_ROUTE_ENABLE    = 0;
    localparam int          B_THERMAL_ENABLE   = 0;
    localparam int          B_USB_EN    = 8;
    localparam int          B_GENERAL_INPUT_ENABLE    = 9;
    localparam int          B_RING_EN   = 10;
    localparam int          B_LID_EN    = 11;
    localparam int          B_THROTTLE_ENABLE    = 4;
    localparam int          B_CLOCK_CONTROL_ENABLE     = 5;
    localparam int          B_SLEEP_EN  = 6;
    localparam int          B_BRST_SEL  = 7;
    localparam int          B_DUTY_LO   = 1;
    localparam int          B_THERMAL_ALARM_IN_BK   = 2;
    localparam int          B_FB_STEP   = 5;
    localparam int          B_LOCK_RES  = 6;
    // Last phase of the eight-tick throttle period, and duty steps of one tick each
    localparam logic [2:0]  TICKS_PER_PERIOD = 3'h7;
    localparam logic [3:0]  DUTY_STEPS  = 4'h8;
    localparam int          CLK_MHZ     = 200;
    localparam int          FB_FINE_US  = 8;
    localparam int          FB_COARSE_US = 1000;
    localparam int          FB_FINE_CYC = FB_FINE_US * CLK_MHZ;
    localparam int          FB_COARSE_CYC = FB_COARSE_US * CLK_MHZ;
    localparam int          THERMAL_ALARM_IN_TICKS_S = 32768;
    localparam int          THERMAL_ALARM_IN_SECONDS = 2;
    localparam logic [2:0]  EXIT_TICKS_NOSLEEP = 3'h2;
    localparam logic [2:0]  EXIT_TICKS_SLEEP   = 3'h4;

    typedef enum logic [4:0] {
        ST_RUN    = 5'h01,
        ST_GRANT  = 5'h02,
        ST_THROT  = 5'h04,
        ST_EXIT   = 5'h08,
        ST_BURST  = 5'h10
    } cct_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       rd;
        logic       wr;
        logic [15:0] wdata;
    } cct_io_req_t;

    typedef struct packed {
        logic ring;
        logic usb;
        logic lid;
        logic gpi;
        logic thermal;
    } cct_evt_t;
endpackage

/* hw/cct_duty_gen.sv */
/*
 * Throttle waveform generator: eight time-base ticks per period, stop-clock
 * asserted for eight ticks less the programmed code (code 0 gives none).
 * Assumes tick is a one-cycle pulse synchronous to i_clk.
 */
`timescale 1ns/1ps
module cct_duty_gen
    import cct_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Control
    input  wire logic       i_run,
    input  wire logic       i_tick,
    input  wire logic [2:0] i_duty,
    // Waveform
    output logic            o_assert
);
    typedef struct packed {
        logic [2:0] phase;
        logic       out;
    } cct_dg_t;

    cct_dg_t s_reg;
    cct_dg_t s_next;

    // Ticks asserted per period: code 1 gives 7 of 8, code 7 gives 1 of 8
    function automatic logic [3:0] on_ticks(input logic [2:0] code);
        if (code == 3'h0) begin
            on_ticks = 4'h0;
        end else begin
            on_ticks = DUTY_STEPS - {1'b0, code};
        end
    endfunction

    always_comb begin
        s_next = s_reg;
        if (!i_run) begin
            s_next.phase = 3'h0;
            s_next.out   = 1'b0;
        end else begin
            if (i_tick) begin
                s_next.phase = (s_reg.phase == TICKS_PER_PERIOD) ? 3'h0
                             : s_reg.phase + 3'h1;
            end
            s_next.out = ({1'b0, s_next.phase} < on_ticks(i_duty));
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_assert = s_reg.out;
endmodule

/* hw/cct_top.sv */
/*
 * Processor clock throttle control: I/O registers, clock control state
 * machine, thermal override, event routing and fast burst step timer.
 * Assumes a synchronous single-cycle I/O port and synchronous inputs.
 */
`timescale 1ns/1ps
module cct_top
    import cct_pkg::*;
#(
    parameter int THERMAL_ALARM_IN_HOLD_CYC = THERMAL_ALARM_IN_SECONDS * THERMAL_ALARM_IN_TICKS_S,
    parameter int FB_COARSE     = FB_COARSE_CYC
)
(
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    // Register port
    input  cct_pkg::cct_io_req_t i_io,
    output logic [15:0]        o_rdata,
    // Time base and events
    input  wire logic          i_tick_32k,
    input  wire logic          i_hw_event,
    input  cct_pkg::cct_evt_t  i_evt,
    input  wire logic          i_thermal_alarm_in_n,
    // Processor pins
    output logic               o_stop_clock_out_n,
    output logic               o_cache_sleep_out,
    // Event outputs
    output logic               o_sci,
    output logic               o_system_mgmt_interrupt,
    output logic               o_resume,
    output logic               o_break_pulse,
    output logic               o_burst_pulse,
    output logic               o_fb_step
);
    import cct_pkg::*;

    typedef struct packed {
        logic [15:0] general_purpose_event_enable;
        logic [7:0]  pctl;
        logic [15:0] global_event_enable;
        logic        route;
        logic [7:0]  fbcnt;
        cct_state_t  st;
        cct_state_t  saved;
        logic        thermal_alarm_in_ovr;
        logic [31:0] thermal_alarm_in_cnt;
        logic [2:0]  exit_cnt;
        logic [31:0] fb_cnt;
        logic        fb_step;
        logic [15:0] rdata;
        logic        stp;
        logic        zz;
        logic        sci;
        logic        smi;
        logic        rsm;
        logic        brk;
        logic        bst;
        logic        alarm_d;
    } cct_s_t;

    cct_s_t s_reg;
    cct_s_t s_next;
    logic   duty_assert;
    logic   duty_run;

    function automatic logic hit(input cct_io_req_t r, input logic [7:0] a);
        hit = (r.addr == a);
    endfunction

    // Throttle waveform runs in throttled grant or thermal override
    assign duty_run = (s_reg.st == ST_THROT) || s_reg.thermal_alarm_in_ovr;

    cct_duty_gen u_duty (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_run    (duty_run),
        .i_tick   (i_tick_32k),
        .i_duty   (s_reg.pctl[B_DUTY_LO +: 3]),
        .o_assert (duty_assert)
    );

    always_comb begin
        logic clock_control_enable;
        logic throttle_enable;
        logic alarm;
        logic brk_ev;
        logic lvl_rd;
        logic [31:0] fb_lim;
        clock_control_enable  = 1'b0;
        throttle_enable = 1'b0;
        alarm  = 1'b0;
        brk_ev = 1'b0;
        lvl_rd = 1'b0;
        fb_lim = '0;
        s_next = s_reg;
        s_next.brk = 1'b0;
        s_next.bst = 1'b0;

        // Register writes
        if (i_io.wr) begin
            if (hit(i_io, OFS_GENERAL_PURPOSE_EVENT_ENABLE))  s_next.general_purpose_event_enable  = i_io.wdata & 16'h0F01;
            if (hit(i_io, OFS_PCTL))  s_next.pctl  = i_io.wdata[7:0];
            if (hit(i_io, OFS_GLOBAL_EVENT_ENABLE)) s_next.global_event_enable = i_io.wdata;
            if (hit(i_io, OFS_ROUTE)) s_next.route = i_io.wdata[B_SCI_ROUTE_ENABLE];
            if (hit(i_io, OFS_FBCNT)) s_next.fbcnt = i_io.wdata[7:0];
        end
        clock_control_enable  = s_next.pctl[B_CLOCK_CONTROL_ENABLE];
        throttle_enable = s_next.pctl[B_THROTTLE_ENABLE];
        lvl_rd = i_io.rd && (hit(i_io, OFS_LEVEL2_ENTRY_REG) || hit(i_io, OFS_LEVEL3_ENTRY_REG));

        // Hardware wake events: stop-break or burst
        brk_ev = i_hw_event && !s_reg.pctl[B_BRST_SEL];
        s_next.bst = i_hw_event && s_reg.pctl[B_BRST_SEL];

        // Thermal override after a long alarm while in any state but ST_RUN
        alarm = !i_thermal_alarm_in_n;
        s_next.alarm_d = alarm;
        if (alarm && s_reg.st != ST_RUN) begin
            if (s_reg.thermal_alarm_in_cnt < THERMAL_ALARM_IN_HOLD_CYC) begin
                s_next.thermal_alarm_in_cnt = s_reg.thermal_alarm_in_cnt + (i_tick_32k ? 32'h1 : 32'h0);
            end else begin
                s_next.thermal_alarm_in_ovr = 1'b1;
            end
        end else if (!alarm) begin
            s_next.thermal_alarm_in_cnt = '0;
            s_next.thermal_alarm_in_ovr = 1'b0;
            if (s_reg.thermal_alarm_in_ovr && s_reg.global_event_enable[B_THERMAL_ALARM_IN_BK]) begin
                brk_ev = 1'b1;
            end
        end
        s_next.brk = brk_ev;

        case (s_reg.st)
            ST_RUN: begin
                if (clock_control_enable && throttle_enable && !lvl_rd) begin
                    s_next.st = ST_THROT;
                end else if (clock_control_enable && lvl_rd) begin
                    s_next.st = ST_GRANT;
                end
            end
            ST_GRANT: begin
                if (!clock_control_enable) begin
                    s_next.st = ST_EXIT;
                end else if (brk_ev && throttle_enable) begin
                    s_next.st = ST_THROT;
                end else if (brk_ev) begin
                    s_next.st = ST_EXIT;
                end
            end
            ST_THROT: begin
                // Break events leave throttling untouched
                if (!clock_control_enable || !throttle_enable) begin
                    s_next.st = ST_RUN;
                end else if (lvl_rd) begin
                    s_next.st = ST_GRANT;
                end
            end
            ST_EXIT: begin
                if (i_tick_32k) begin
                    s_next.exit_cnt = s_reg.exit_cnt + 3'h1;
                end
                if (s_reg.exit_cnt == (s_reg.pctl[B_SLEEP_EN] ? EXIT_TICKS_SLEEP
                                                               : EXIT_TICKS_NOSLEEP)) begin
                    s_next.st       = ST_RUN;
                    s_next.exit_cnt = 3'h0;
                end
            end
            default: s_next.st = ST_RUN;
        endcase

        // Stop-clock and cache sleep
        if (s_reg.thermal_alarm_in_ovr || s_reg.st == ST_THROT) begin
            s_next.stp = duty_assert;
        end else begin
            s_next.stp = (s_reg.st == ST_GRANT) || (s_reg.st == ST_EXIT);
        end
        s_next.zz = s_next.stp && s_reg.pctl[B_SLEEP_EN];

        // Event routing
        s_next.sci = s_reg.route && ((i_evt.ring && s_reg.general_purpose_event_enable[B_RING_EN])
                   || (i_evt.usb && s_reg.general_purpose_event_enable[B_USB_EN])
                   || (i_evt.lid && s_reg.general_purpose_event_enable[B_LID_EN])
                   || (i_evt.gpi && s_reg.general_purpose_event_enable[B_GENERAL_INPUT_ENABLE])
                   || (i_evt.thermal && s_reg.general_purpose_event_enable[B_THERMAL_ENABLE]));
        s_next.smi = !s_reg.route && ((i_evt.lid && s_reg.general_purpose_event_enable[B_LID_EN])
                   || (i_evt.gpi && s_reg.general_purpose_event_enable[B_GENERAL_INPUT_ENABLE])
                   || (i_evt.thermal && s_reg.general_purpose_event_enable[B_THERMAL_ENABLE]));
        s_next.rsm = (i_evt.ring && s_reg.general_purpose_event_enable[B_RING_EN])
                   || (i_evt.usb && s_reg.general_purpose_event_enable[B_USB_EN])
                   || (i_evt.lid && s_reg.general_purpose_event_enable[B_LID_EN])
                   || (i_evt.gpi && s_reg.general_purpose_event_enable[B_GENERAL_INPUT_ENABLE]);

        // Fast burst step timer
        if (s_reg.fbcnt[B_FB_STEP] || s_reg.fbcnt[B_LOCK_RES]) begin
            fb_lim = FB_FINE_CYC;
        end else begin
            fb_lim = FB_COARSE;
        end
        s_next.fb_step = 1'b0;
        if (s_reg.fb_cnt >= fb_lim - 32'h1) begin
            s_next.fb_cnt  = '0;
            s_next.fb_step = 1'b1;
        end else begin
            s_next.fb_cnt = s_reg.fb_cnt + 32'h1;
        end

        // Register reads
        s_next.rdata = 16'h0000;
        if (i_io.rd) begin
            case (i_io.addr)
                OFS_GENERAL_PURPOSE_EVENT_ENABLE:   s_next.rdata = s_reg.general_purpose_event_enable;
                OFS_PCTL:   s_next.rdata = {8'h00, s_reg.pctl};
                OFS_GLOBAL_EVENT_ENABLE:  s_next.rdata = s_reg.global_event_enable;
                OFS_ROUTE:  s_next.rdata = {15'h0000, s_reg.route};
                OFS_FBCNT:  s_next.rdata = {8'h00, s_reg.fbcnt};
                OFS_STATE:  s_next.rdata = {10'h000, s_reg.thermal_alarm_in_ovr, s_reg.st};
                OFS_INTPIN: s_next.rdata = {8'h00, RST8};
                default:    s_next.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_reg       <= '0;
            s_reg.general_purpose_event_enable  <= RST16;
            s_reg.pctl  <= RST8;
            s_reg.global_event_enable <= RST16;
            s_reg.fbcnt <= RST8;
            s_reg.st    <= ST_RUN;
            s_reg.saved <= ST_RUN;
            s_reg.alarm_d <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_rdata                 = s_reg.rdata;
    assign o_stop_clock_out_n      = !s_reg.stp;
    assign o_cache_sleep_out       = s_reg.zz;
    assign o_sci                   = s_reg.sci;
    assign o_system_mgmt_interrupt = s_reg.smi;
    assign o_resume                = s_reg.rsm;
    assign o_break_pulse           = s_reg.brk;
    assign o_burst_pulse           = s_reg.bst;
    assign o_fb_step               = s_reg.fb_step;
endmodule

/* testbench/cct_top_properties.sv */
/* Port-level checker for cct_top: shadows control writes seen on i_io.
   Assumes it is bound into cct_top and that i_tick_32k is a one-cycle pulse. */
`timescale 1ns/1ps
module cct_top_properties
    import cct_pkg::*;
#(
    parameter int THERMAL_ALARM_IN_HOLD_CYC = 4,
    parameter int FB_COARSE     = 50
)
(
    // Clock, reset, register port
    input wire logic             i_clk,
    input wire logic             i_rst_n,
    input cct_pkg::cct_io_req_t  i_io,
    // Time base and events
    input wire logic             i_tick_32k,
    input wire logic             i_hw_event,
    input cct_pkg::cct_evt_t     i_evt,
    input wire logic             i_thermal_alarm_in_n,
    // Watched outputs
    input wire logic             o_stop_clock_out_n,
    input wire logic             o_cache_sleep_out,
    input wire logic             o_sci,
    input wire logic             o_system_mgmt_interrupt,
    input wire logic             o_resume,
    input wire logic             o_break_pulse,
    input wire logic             o_burst_pulse,
    input wire logic             o_fb_step
);
    logic [15:0] general_purpose_event_enable_reg;
    logic [7:0]  pctl_reg;
    logic        route_reg, lvl_reg, fine_reg, seen_reg;
    logic [2:0]  tk_reg;
    logic [11:0] gap_reg;
    logic        wake, sci_src;
    assign wake = (i_evt.lid && general_purpose_event_enable_reg[B_LID_EN]) || (i_evt.gpi && general_purpose_event_enable_reg[B_GENERAL_INPUT_ENABLE])
        || (i_evt.ring && general_purpose_event_enable_reg[B_RING_EN]) || (i_evt.usb && general_purpose_event_enable_reg[B_USB_EN]);
    assign sci_src = route_reg && (wake || (i_evt.thermal && general_purpose_event_enable_reg[B_THERMAL_ENABLE]));
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            general_purpose_event_enable_reg  <= RST16;
            pctl_reg  <= RST8;
            route_reg <= 1'b0;
            lvl_reg   <= 1'b0;
            fine_reg  <= 1'b0;
            seen_reg  <= 1'b0;
            tk_reg    <= 3'h7;
            gap_reg   <= 12'h000;
        end else begin
            if (i_io.wr && i_io.addr == OFS_GENERAL_PURPOSE_EVENT_ENABLE) general_purpose_event_enable_reg <= i_io.wdata;
            if (i_io.wr && i_io.addr == OFS_ROUTE) route_reg <= i_io.wdata[B_SCI_ROUTE_ENABLE];
            // Ticks since the last control write, saturating
            if (i_io.wr && i_io.addr == OFS_PCTL) begin
                pctl_reg <= i_io.wdata[7:0];
                lvl_reg  <= 1'b0;
                tk_reg   <= 3'h0;
            end else if (i_tick_32k && tk_reg != 3'h7) tk_reg <= tk_reg + 3'h1;
            if (i_io.rd && (i_io.addr == OFS_LEVEL2_ENTRY_REG || i_io.addr == OFS_LEVEL3_ENTRY_REG)) lvl_reg <= 1'b1;
            if (i_io.wr && i_io.addr == OFS_FBCNT) begin
                fine_reg <= i_io.wdata[B_FB_STEP];
                seen_reg <= 1'b0;
            end else if (o_fb_step) seen_reg <= 1'b1;
            if (o_fb_step) gap_reg <= 12'h000;
            else if (gap_reg != 12'hFFF) gap_reg <= gap_reg + 12'h001;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    reset_idle_a: assert property (disable iff (1'b0) !i_rst_n |=> o_stop_clock_out_n
        && !o_sci && !o_system_mgmt_interrupt) else $error("outputs busy after reset");
    full_speed_a: assert property (tk_reg == 3'h7 && i_thermal_alarm_in_n &&
        (!pctl_reg[B_CLOCK_CONTROL_ENABLE] || (!lvl_reg && (!pctl_reg[B_THROTTLE_ENABLE] || pctl_reg[3:1] == 3'h0)))
        |-> o_stop_clock_out_n && !o_cache_sleep_out) else $error("clock stopped at full speed");
    break_evt_a: assert property (i_hw_event && pctl_reg[B_CLOCK_CONTROL_ENABLE] && !pctl_reg[B_BRST_SEL]
        |-> ##[0:2] o_break_pulse) else $error("wake event gave no break");
    burst_evt_a: assert property (i_hw_event && pctl_reg[B_CLOCK_CONTROL_ENABLE] && pctl_reg[B_BRST_SEL]
        |-> ##[0:2] o_burst_pulse) else $error("wake event gave no burst");
    lid_smi_a: assert property (i_evt.lid && general_purpose_event_enable_reg[B_LID_EN] && !route_reg
        |-> ##[0:2] o_system_mgmt_interrupt) else $error("lid gave no management interrupt");
    gpi_sci_a: assert property (i_evt.gpi && general_purpose_event_enable_reg[B_GENERAL_INPUT_ENABLE] && route_reg
        |-> ##[0:2] o_sci) else $error("general input gave no sci");
    sci_cause_a: assert property ($rose(o_sci) |-> sci_src || $past(sci_src)
        || $past(sci_src, 2)) else $error("sci without enabled cause");
    resume_cause_a: assert property ($rose(o_resume) |-> wake || $past(wake)
        || $past(wake, 2)) else $error("resume without enabled cause");
    fb_fine_a: assert property (o_fb_step && fine_reg && seen_reg
        |-> gap_reg >= 12'd1598 && gap_reg <= 12'd1600) else $error("fine step spacing wrong");
    throttle_c: cover property (!o_stop_clock_out_n ##1 o_stop_clock_out_n);
    break_c: cover property (o_break_pulse);
    step_c: cover property (o_fb_step && fine_reg);
endmodule
bind cct_top cct_top_properties #(.THERMAL_ALARM_IN_HOLD_CYC(THERMAL_ALARM_IN_HOLD_CYC), .FB_COARSE(FB_COARSE)) u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_io(i_io), .i_tick_32k(i_tick_32k),
    .i_hw_event(i_hw_event), .i_evt(i_evt), .i_thermal_alarm_in_n(i_thermal_alarm_in_n),
    .o_stop_clock_out_n(o_stop_clock_out_n), .o_cache_sleep_out(o_cache_sleep_out),
    .o_sci(o_sci), .o_system_mgmt_interrupt(o_system_mgmt_interrupt), .o_resume(o_resume),
    .o_break_pulse(o_break_pulse), .o_burst_pulse(o_burst_pulse), .o_fb_step(o_fb_step));

/* testbench/cct_cpu_model.sv */
/* Processor side: time base source and stop-clock duty meter over one period.
   Assumes the time base is sped up to one tick every TICK_CYC clocks. */
`timescale 1ns/1ps
module cct_cpu_model #(
    parameter int TICK_CYC = 16
)
(
    // Clock and control
    input wire logic  i_clk,
    input wire logic  i_stop_clock_out_n,
    input wire logic  i_start,
    // Time base and result
    output logic       o_tick = 1'b0,
    output logic       o_done = 1'b0,
    output logic [3:0] o_low  = 4'h0
);
    int cyc  = 0;
    int left = 0;
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        cyc    <= (cyc == TICK_CYC - 1) ? 0 : cyc + 1;
        o_tick <= (cyc == TICK_CYC - 1);
        if (i_start) begin
            left  <= 8;
            o_low <= 4'h0;
        end else if (o_tick && left > 0) begin
            if (!i_stop_clock_out_n) o_low <= o_low + 4'h1;
            left   <= left - 1;
            o_done <= (left == 1);
        end
    end
endmodule

/* testbench/cct_top_tb.sv */
/* Self-checking bench for cct_top: register access, throttle duty, breaks,
   thermal break, event routing and fine burst steps. Assumes cct_cpu_model. */
`timescale 1ns/1ps
module cct_top_tb;
    import cct_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, hw_event = 1'b0, alarm_n = 1'b1;
    logic        start = 1'b0, want = 1'b0, want_q = 1'b0;
    cct_io_req_t io = '0;
    cct_evt_t    evt = '0;
    logic [15:0] rdata;
    logic        stop_n, sleep, sci, smi, resume, brk, bst, fbs, tick, done;
    logic [3:0]  low;
    logic [31:0] seed = 32'd98;
    logic [15:0] expq[$];
    int          num_errors = 0, checks = 0, cycles = 0, brk_cnt = 0;
    always #2.5 clk = ~clk;
    cct_top #(.THERMAL_ALARM_IN_HOLD_CYC(4), .FB_COARSE(50)) DUT (.i_clk(clk), .i_rst_n(rst_n),
        .i_io(io), .o_rdata(rdata), .i_tick_32k(tick), .i_hw_event(hw_event), .i_evt(evt),
        .i_thermal_alarm_in_n(alarm_n), .o_stop_clock_out_n(stop_n), .o_cache_sleep_out(sleep),
        .o_sci(sci), .o_system_mgmt_interrupt(smi), .o_resume(resume), .o_break_pulse(brk),
        .o_burst_pulse(bst), .o_fb_step(fbs));
    cct_cpu_model #(.TICK_CYC(16)) u_cpu (.i_clk(clk), .i_stop_clock_out_n(stop_n),
        .i_start(start), .o_tick(tick), .o_done(done), .o_low(low));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One register cycle; a read may note its expected answer
    task automatic op(input logic [7:0] a, input logic r, input logic [15:0] d,
                      input logic w, input logic [15:0] e);
        @(posedge clk);
        io   <= {a, r, !r, d};
        want <= w;
        if (w) expq.push_back(e);
        @(posedge clk);
        io   <= '0;
        want <= 1'b0;
    endtask
    // Settle two periods, then count stop-clock low ticks over one period
    task automatic meas(input logic [15:0] e);
        repeat (260) @(posedge clk);
        expq.push_back(e);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            if (done === 1'b1) break;
        end
        @(posedge clk);
    endtask
    task automatic hw();
        @(posedge clk);
        hw_event <= 1'b1;
        @(posedge clk);
        hw_event <= 1'b0;
    endtask
    always @(posedge clk) begin
        want_q <= want;
        if (brk === 1'b1) brk_cnt <= brk_cnt + 1;
        if (want_q === 1'b1) check(rdata, expq.pop_front());
        if (done === 1'b1) check({12'h000, low}, expq.pop_front());
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        int b0;
        logic [31:0] r;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        op(OFS_GENERAL_PURPOSE_EVENT_ENABLE, 1, 0, 1, RST16);
        op(OFS_PCTL, 1, 0, 1, RST16);
        op(OFS_GLOBAL_EVENT_ENABLE, 1, 0, 1, RST16);
        op(OFS_GENERAL_PURPOSE_EVENT_ENABLE, 0, 16'hFFFF, 0, 0);
        op(OFS_GENERAL_PURPOSE_EVENT_ENABLE, 1, 0, 1, 16'h0F01);
        op(OFS_PCTL, 0, 16'h0084, 0, 0);
        op(OFS_PCTL, 1, 0, 1, 16'h0084);
        op(OFS_GLOBAL_EVENT_ENABLE, 0, 16'h0004, 0, 0);
        op(OFS_GLOBAL_EVENT_ENABLE, 1, 0, 1, 16'h0004);
        op(OFS_INTPIN, 0, 16'h00FF, 0, 0);
        op(OFS_INTPIN, 1, 0, 1, RST16);
        op(8'h7F, 0, 16'hFFFF, 0, 0);
        op(8'h7F, 1, 0, 1, 16'h0000);
        $display("registers done");
        for (int c = 0; c < 8; c++) begin
            op(OFS_PCTL, 0, 16'h0030 | 16'(c << 1), 0, 0);
            meas(c == 0 ? 16'h0000 : 16'(8 - c));
        end
        op(OFS_PCTL, 0, 16'h0038, 0, 0);
        hw();
        meas(16'h0004);
        op(OFS_PCTL, 0, 16'h00B8, 0, 0);
        hw();
        meas(16'h0004);
        op(OFS_PCTL, 0, 16'h0028, 0, 0);
        meas(16'h0000);
        op(OFS_PCTL, 0, 16'h0038, 0, 0);
        op(OFS_PCTL, 0, 16'h0018, 0, 0);
        meas(16'h0000);
        op(OFS_PCTL, 0, 16'h0034, 0, 0);
        op(OFS_LEVEL2_ENTRY_REG, 1, 0, 0, 0);
        meas(16'h0008);
        hw();
        meas(16'h0006);
        op(OFS_PCTL, 0, 16'h0020, 0, 0);
        op(OFS_LEVEL2_ENTRY_REG, 1, 0, 0, 0);
        meas(16'h0008);
        hw();
        meas(16'h0000);
        $display("throttle done");
        op(OFS_LEVEL2_ENTRY_REG, 1, 0, 0, 0);
        b0 = brk_cnt;
        alarm_n <= 1'b0;
        repeat (150) @(posedge clk);
        alarm_n <= 1'b1;
        repeat (40) @(posedge clk);
        check(16'(brk_cnt != b0), 16'h0001);
        b0 = brk_cnt;
        alarm_n <= 1'b0;
        hw();
        alarm_n <= 1'b1;
        repeat (3) @(posedge clk);
        check(16'(brk_cnt != b0), 16'h0001);
        $display("thermal done");
        op(OFS_GENERAL_PURPOSE_EVENT_ENABLE, 0, 16'h0F01, 0, 0);
        for (int i = 0; i < 64; i++) begin
            if (i == 32) op(OFS_ROUTE, 0, 16'h0001, 0, 0);
            @(posedge clk);
            r = xs();
            evt <= cct_evt_t'(r[4:0]);
            hw_event <= r[5];
            @(posedge clk);
            evt <= '0;
            hw_event <= 1'b0;
            repeat (3) @(posedge clk);
        end
        $display("events done");
        op(OFS_FBCNT, 0, 16'h0020, 0, 0);
        repeat (4000) @(posedge clk);
        $display("fast burst done");
        end_of_test();
    end
endmodule
